// file: scs_spi_control.sv
// Control and status register of the serial peripheral, with link event crossing.
`timescale 1ns/1ps
`default_nettype none
module scs_spi_control
(
    input wire logic clk,
    input wire logic rst_n,
    input wire logic link_clk,
    input wire logic sfr_wr,
    input wire logic sfr_rd,
    input wire logic [7:0] sfr_addr,
    input wire logic [7:0] sfr_wdata,
    output logic [7:0] sfr_rdata,
    input wire logic data_reg_wr,
    input wire logic tx_load,
    input wire logic rx_buffer_full,
    input wire logic master_enable,
    input wire logic link_frame_active,
    input wire logic slave_select_pin_in,
    output logic slave_select_pin_out,
    output logic slave_select_pin_oe,
    output logic slave_select_routed,
    output logic port_enable,
    output logic irq_req
);
    // Transfer-done flag, set at the end of every full frame while the peripheral is enabled.
    logic done_q;
    logic done_d;
    // Write-collision flag, set by a data write into a buffer not yet drained.
    logic write_collision_flag_q;
    logic write_collision_flag_d;
    // Mode-fault flag, set when another master selects us while we are master.
    logic mode_fault_flag_q;
    logic mode_fault_flag_d;
    // Receive-overrun flag, set when a slave frame ends on unread data.
    logic ovrn_q;
    logic ovrn_d;
    // Select-mode field; bit 1 is the high bit, bit 0 the low bit.
    // Mode 00 is three-wire, 01 four-wire with an input pin, 1x single master.
    logic [1:0] sel_q;
    logic [1:0] sel_d;
    // Transmit-buffer-empty status; software can only read it.
    logic txe_q;
    logic txe_d;
    // Peripheral enable bit.
    logic en_q;
    logic en_d;
    // Read data, registered so the bus sees it one cycle after the read.
    logic [7:0] rdata_q;
    logic [7:0] rdata_d;
    // Level driven onto the select pin in single-master mode.
    logic ss_out_q;
    logic ss_out_d;
    // Output enable of the select pin, high while we drive it.
    logic ss_oe_q;
    logic ss_oe_d;
    // Low while the select signal is kept off the port pins.
    logic routed_q;
    logic routed_d;
    // Interrupt request, the OR of the three interrupting flags.
    logic irq_q;
    logic irq_d;
    // Frame-done toggle as it leaves the link domain.
    logic done_tog;
    // The same toggle after two system-clock flops.
    logic done_tog_s;
    // Last synchronised toggle value, for edge detection.
    logic done_tog_last_q;
    logic done_tog_last_d;
    // One-cycle pulse for each finished frame.
    logic frame_end;
    // Select pin after two flops; idle high.
    logic ss_in_s;
    // Write strobe for the control register.
    logic ctrl_wr;
    // Read strobe for the control register.
    logic ctrl_rd;
    // Register value as software reads it.
    logic [7:0] ctrl_value;

    // Link-domain frame counter.
    // It runs on the link clock and flips a toggle once per full frame.
    // A toggle, not a pulse, crosses the domains, so no event is lost as long as
    // frames end at least two system-clock cycles apart.
    // A frame cut short never reaches its last bit and leaves the toggle alone.
    // The counter clears itself whenever the frame signal drops.
    scs_link_counter #(.BITS(scs_pkg::SCS_FRAME_BITS)) u_link
    (
        .link_clk(link_clk),
        .rst_n(rst_n),
        .frame_active(link_frame_active),
        .done_toggle(done_tog)
    );

    // Bring the frame toggle into the clk domain.
    // It rests low after reset, as its source does, so no false edge follows.
    scs_sync #(.RESET_VAL(1'b0)) u_sync_done
    (
        .clk(clk),
        .rst_n(rst_n),
        .async_in(done_tog),
        .sync_out(done_tog_s)
    );

    // Select pin is idle high, so its synchroniser resets high.
    scs_sync #(.RESET_VAL(1'b1)) u_sync_ss
    (
        .clk(clk),
        .rst_n(rst_n),
        .async_in(slave_select_pin_in),
        .sync_out(ss_in_s)
    );

    // Edge of the synchronised toggle marks one finished frame.
    assign frame_end = done_tog_s ^ done_tog_last_q;
    // Only the control register address is decoded; other addresses are ignored.
    assign ctrl_wr = sfr_wr && (sfr_addr == scs_pkg::SCS_CTRL_ADDR);
    // Read data is taken at the read edge and shown one cycle later.
    assign ctrl_rd = sfr_rd && (sfr_addr == scs_pkg::SCS_CTRL_ADDR);

    // Current register image as software sees it.
    always_comb
    begin
        // Start from zero, then place each field at its bit position.
        ctrl_value = '0;
        ctrl_value[scs_pkg::SCS_BIT_DONE] = done_q;
        ctrl_value[scs_pkg::SCS_BIT_WRITE_COLLISION_FLAG] = write_collision_flag_q;
        ctrl_value[scs_pkg::SCS_BIT_MODE_FAULT_FLAG] = mode_fault_flag_q;
        ctrl_value[scs_pkg::SCS_BIT_OVRN] = ovrn_q;
        ctrl_value[scs_pkg::SCS_BIT_SELH] = sel_q[1];
        ctrl_value[scs_pkg::SCS_BIT_SELL] = sel_q[0];
        ctrl_value[scs_pkg::SCS_BIT_TXE] = txe_q;
        ctrl_value[scs_pkg::SCS_BIT_EN] = en_q;
    end

    // Next values of the control register; hardware sets beat software clears.
    always_comb
    begin
        // Every field holds its value unless written or set.
        done_d = done_q;
        write_collision_flag_d = write_collision_flag_q;
        mode_fault_flag_d = mode_fault_flag_q;
        ovrn_d = ovrn_q;
        sel_d = sel_q;
        txe_d = txe_q;
        en_d = en_q;
        // Software writes every writable bit; TXE is read-only.
        if (ctrl_wr)
        begin
            // Flags are cleared here and nowhere else.
            // Writing 0 clears a flag; writing 1 sets it, which tests may use.
            done_d = sfr_wdata[scs_pkg::SCS_BIT_DONE];
            write_collision_flag_d = sfr_wdata[scs_pkg::SCS_BIT_WRITE_COLLISION_FLAG];
            mode_fault_flag_d = sfr_wdata[scs_pkg::SCS_BIT_MODE_FAULT_FLAG];
            ovrn_d = sfr_wdata[scs_pkg::SCS_BIT_OVRN];
            // The new select mode reaches the pin controls in the same cycle.
            sel_d = {sfr_wdata[scs_pkg::SCS_BIT_SELH], sfr_wdata[scs_pkg::SCS_BIT_SELL]};
            en_d = sfr_wdata[scs_pkg::SCS_BIT_EN];
        end
        // Events count only while the peripheral is on.
        // They come after the write, so a set in the clearing cycle is never lost.
        if (en_q)
        begin
            if (frame_end)
            begin
                // One pulse per full frame from the crossing logic.
                done_d = 1'b1;
            end
            if (data_reg_wr && !txe_q)
            begin
                // The buffer has not drained into the shifter yet.
                write_collision_flag_d = 1'b1;
            end
            if (!ss_in_s && master_enable && sel_q == scs_pkg::SCS_SEL_4WIRE_IN)
            begin
                // Another master pulled our select low while we act as master.
                mode_fault_flag_d = 1'b1;
            end
            if (frame_end && !master_enable && rx_buffer_full)
            begin
                // The last bit landed while the receive buffer was still unread.
                ovrn_d = 1'b1;
            end
        end
        // buffer empty tracking
        // Tracking runs even while disabled, so the status never goes stale.
        if (tx_load)
        begin
            // The shifter took the byte, so the buffer is free again.
            txe_d = 1'b1;
        end
        else if (data_reg_wr && txe_q)
        begin
            // A byte now waits in the buffer for the shifter.
            txe_d = 1'b0;
        end
    end

    // Hardware only ever sets flags; the write path is the only way down.
    // only software clears flags
    always_ff @(posedge clk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            // Each field resets to its bit of the package constant.
            done_q <= scs_pkg::SCS_CTRL_RESET[scs_pkg::SCS_BIT_DONE];
            write_collision_flag_q <= scs_pkg::SCS_CTRL_RESET[scs_pkg::SCS_BIT_WRITE_COLLISION_FLAG];
            mode_fault_flag_q <= scs_pkg::SCS_CTRL_RESET[scs_pkg::SCS_BIT_MODE_FAULT_FLAG];
            ovrn_q <= scs_pkg::SCS_CTRL_RESET[scs_pkg::SCS_BIT_OVRN];
            sel_q <= scs_pkg::SCS_CTRL_RESET[scs_pkg::SCS_BIT_SELH:scs_pkg::SCS_BIT_SELL];
            txe_q <= scs_pkg::SCS_CTRL_RESET[scs_pkg::SCS_BIT_TXE];
            en_q <= scs_pkg::SCS_CTRL_RESET[scs_pkg::SCS_BIT_EN];
        end
        else
        begin
            // Load the next values.
            done_q <= done_d;
            write_collision_flag_q <= write_collision_flag_d;
            mode_fault_flag_q <= mode_fault_flag_d;
            ovrn_q <= ovrn_d;
            sel_q <= sel_d;
            txe_q <= txe_d;
            en_q <= en_d;
        end
    end

    // Next values of read data, pins and interrupt request.
    always_comb
    begin
        // Read data is zero unless the control register is read.
        rdata_d = ctrl_rd ? ctrl_value : 8'h00;
        // Remember the toggle for the next edge test.
        done_tog_last_d = done_tog_s;
        // select pin routing
        // Pin controls follow the next field values, so they change with the register.
        routed_d = (sel_d != scs_pkg::SCS_SEL_3WIRE);
        // The pin is driven only in single-master mode and only while enabled.
        ss_oe_d = sel_d[1] && en_d;
        // Single-master mode drives the low select bit; otherwise the pin rests high.
        ss_out_d = sel_d[1] ? sel_d[0] : 1'b1;
        // interrupt request
        // The request stands as long as any interrupting flag is set.
        irq_d = done_d || mode_fault_flag_d || ovrn_d;
    end

    // Register the outputs so every port comes from a flop.
    always_ff @(posedge clk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            // Outputs rest in their idle state during reset.
            rdata_q <= 8'h00;
            done_tog_last_q <= 1'b0;
            routed_q <= 1'b1;
            ss_oe_q <= 1'b0;
            ss_out_q <= 1'b1;
            irq_q <= 1'b0;
        end
        else
        begin
            // Register the next values.
            rdata_q <= rdata_d;
            done_tog_last_q <= done_tog_last_d;
            routed_q <= routed_d;
            ss_oe_q <= ss_oe_d;
            ss_out_q <= ss_out_d;
            irq_q <= irq_d;
        end
    end

    // Port drivers.
    assign sfr_rdata = rdata_q;
    assign slave_select_pin_out = ss_out_q;
    assign slave_select_pin_oe = ss_oe_q;
    assign slave_select_routed = routed_q;
    // Enable comes straight from its register bit.
    assign port_enable = en_q;
    // The interrupt request comes straight from its flop.
    assign irq_req = irq_q;
endmodule
`default_nettype wire

// file: scs_pkg.sv
// Shared constants for the serial port control and status block.
package scs_pkg;
    // Register address on the special-function-register bus.
    localparam logic [7:0] SCS_CTRL_ADDR = 8'hf8;
    // Reset value of the control register.
    localparam logic [7:0] SCS_CTRL_RESET = 8'h06;
    // Bit positions inside the control register.
    localparam int SCS_BIT_DONE = 7;
    localparam int SCS_BIT_WRITE_COLLISION_FLAG = 6;
    localparam int SCS_BIT_MODE_FAULT_FLAG = 5;
    localparam int SCS_BIT_OVRN = 4;
    localparam int SCS_BIT_SELH = 3;
    localparam int SCS_BIT_SELL = 2;
    localparam int SCS_BIT_TXE = 1;
    localparam int SCS_BIT_EN = 0;
    // Select-mode encodings.
    localparam logic [1:0] SCS_SEL_3WIRE = 2'h0;
    localparam logic [1:0] SCS_SEL_4WIRE_IN = 2'h1;
    // Number of data bits in one transfer.
    localparam int SCS_FRAME_BITS = 8;
    // Link-domain frame state.
    typedef enum logic [1:0] {SCS_LK_IDLE, SCS_LK_SHIFT, SCS_LK_LAST} scs_link_state_t;
endpackage

// file: scs_sync.sv
// Two-flop synchroniser for a level crossing into the clk domain.
`timescale 1ns/1ps
`default_nettype none
module scs_sync
#(
    parameter logic RESET_VAL = 1'b0
)
(
    input wire logic clk,
    input wire logic rst_n,
    input wire logic async_in,
    output logic sync_out
);
    // First stage is read only by the second stage.
    logic meta_q;
    logic meta_d;
    logic sync_q;
    logic sync_d;

    // Next values simply shift the input along.
    always_comb
    begin
        meta_d = async_in;
        sync_d = meta_q;
    end

    // Register both stages.
    always_ff @(posedge clk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            meta_q <= RESET_VAL;
            sync_q <= RESET_VAL;
        end
        else
        begin
            meta_q <= meta_d;
            sync_q <= sync_d;
        end
    end

    assign sync_out = sync_q;
endmodule
`default_nettype wire

// file: scs_link_counter.sv
// Link-clock bit counter that toggles an event flag at each frame's last bit.
`timescale 1ns/1ps
`default_nettype none
module scs_link_counter
#(
    parameter int BITS = scs_pkg::SCS_FRAME_BITS
)
(
    input wire logic link_clk,
    input wire logic rst_n,
    input wire logic frame_active,
    output logic done_toggle
);
    // Bit count within the current frame.
    logic [$clog2(BITS)-1:0] cnt_q;
    logic [$clog2(BITS)-1:0] cnt_d;
    // Toggles once per completed frame, read by the clk domain.
    logic tog_q;
    logic tog_d;
    scs_pkg::scs_link_state_t st_q;
    scs_pkg::scs_link_state_t st_d;
    // Clears the count whenever the frame signal drops. The link clock stands
    // still between frames, so a cut frame could never be seen on a clock edge.
    logic frame_rst_n;

    assign frame_rst_n = rst_n && frame_active;

    // Count shift edges; the last edge flips the toggle.
    always_comb
    begin
        cnt_d = cnt_q;
        st_d = st_q;
        case (st_q)
            scs_pkg::SCS_LK_IDLE:
            begin
                cnt_d = '0;
                if (frame_active)
                begin
                    cnt_d = $bits(cnt_d)'(1);
                    st_d = scs_pkg::SCS_LK_SHIFT;
                end
            end
            scs_pkg::SCS_LK_SHIFT:
            begin
                if (!frame_active)
                begin
                    st_d = scs_pkg::SCS_LK_IDLE;
                end
                else if (cnt_q == $bits(cnt_q)'(BITS - 1))
                begin
                    // Last bit of the frame; the toggle flips in its own process.
                    st_d = scs_pkg::SCS_LK_LAST;
                end
                else
                begin
                    cnt_d = cnt_q + 1'b1;
                end
            end
            scs_pkg::SCS_LK_LAST:
            begin
                // Back-to-back frames restart counting at once.
                cnt_d = $bits(cnt_d)'(1);
                st_d = frame_active ? scs_pkg::SCS_LK_SHIFT : scs_pkg::SCS_LK_IDLE;
            end
            default:
            begin
                st_d = scs_pkg::SCS_LK_IDLE;
            end
        endcase
    end

    // The toggle flips on the last bit of a full frame.
    always_comb
    begin
        tog_d = tog_q;
        if (st_q == scs_pkg::SCS_LK_SHIFT && frame_active && cnt_q == $bits(cnt_q)'(BITS - 1))
        begin
            tog_d = ~tog_q;
        end
    end

    // Register the bit count and frame state; a dropped frame clears them.
    always_ff @(posedge link_clk or negedge frame_rst_n)
    begin
        if (!frame_rst_n)
        begin
            cnt_q <= '0;
            st_q <= scs_pkg::SCS_LK_IDLE;
        end
        else
        begin
            cnt_q <= cnt_d;
            st_q <= st_d;
        end
    end

    // Register the toggle; only the chip reset clears it.
    always_ff @(posedge link_clk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            tog_q <= 1'b0;
        end
        else
        begin
            tog_q <= tog_d;
        end
    end

    assign done_toggle = tog_q;
endmodule
`default_nettype wire

// file: scs_spi_control_assertions.sv
// Port-level checks of the serial control block.
`timescale 1ns/1ps
`default_nettype none
module scs_spi_control_assertions
(
    input wire logic clk,
    input wire logic rst_n,
    input wire logic sfr_wr,
    input wire logic sfr_rd,
    input wire logic [7:0] sfr_addr,
    input wire logic [7:0] sfr_wdata,
    input wire logic [7:0] sfr_rdata,
    input wire logic slave_select_pin_out,
    input wire logic slave_select_pin_oe,
    input wire logic slave_select_routed,
    input wire logic port_enable,
    input wire logic irq_req
);
    // Strobes for a write and a read of the control register.
    logic cw;
    logic cr;
    assign cw = sfr_wr && sfr_addr == 8'hf8;
    assign cr = sfr_rd && sfr_addr == 8'hf8;
    default clocking dc @(posedge clk);
    endclocking
    default disable iff (!rst_n);
    rst_val_a: assert property ($rose(rst_n) |-> !irq_req && !port_enable && slave_select_routed)
        else $error("Outputs not at reset state.");
    en_set_a: assert property (cw |=> port_enable == $past(sfr_wdata[0]))
        else $error("Enable does not follow write.");
    en_off_a: assert property ($fell(port_enable) |=> !slave_select_pin_oe)
        else $error("Select driven while disabled.");
    unrouted_a: assert property (cw && sfr_wdata[3:2] == 2'h0 ##1 !sfr_wr |=> !slave_select_routed)
        else $error("Select routed in mode zero.");
    in_mode_a: assert property (cw && sfr_wdata[3:2] == 2'h1 ##1 !sfr_wr |=>
        slave_select_routed && !slave_select_pin_oe) else $error("Select not an input.");
    out_mode_a: assert property (cw && sfr_wdata[3] && sfr_wdata[0] ##1 !sfr_wr |=>
        slave_select_pin_oe && slave_select_pin_out == $past(sfr_wdata[2], 2)) else $error("Select not driven.");
    done_irq_a: assert property (cr ##1 sfr_rdata[7] |-> irq_req)
        else $error("Done flag without request.");
    fault_irq_a: assert property (cr ##1 sfr_rdata[5] |-> irq_req)
        else $error("Fault flag without request.");
    sticky_a: assert property (irq_req && !sfr_wr && !$past(sfr_wr) |=> irq_req)
        else $error("Flag cleared without a write.");
endmodule
bind scs_spi_control scs_spi_control_assertions u_scs_spi_control_assertions (.clk, .rst_n, .sfr_wr,
    .sfr_rd, .sfr_addr, .sfr_wdata, .sfr_rdata, .slave_select_pin_out, .slave_select_pin_oe,
    .slave_select_routed, .port_enable, .irq_req);
`default_nettype wire

// file: scs_link_partner.sv
// External serial master that selects the device and clocks frames.
`timescale 1ns/1ps
`default_nettype none
module scs_link_partner
(
    input wire logic go,
    input wire logic [3:0] nbits,
    input wire logic hold_sel,
    output logic link_clk,
    output logic frame_active,
    output logic sel_pin,
    output logic busy
);
    // Released select rests high on its pull-up.
    logic sel_q = 1'b1;
    assign sel_pin = sel_q && !hold_sel;
    initial
    begin
        link_clk = 1'b0;
        frame_active = 1'b0;
        busy = 1'b0;
    end
    // The clock stands still outside a frame of nbits rising edges.
    always @(posedge go)
    begin
        busy = 1'b1;
        sel_q = 1'b0;
        // An odd lead time keeps link edges off the system clock edges.
        #213 frame_active = 1'b1;
        repeat (nbits)
        begin
            #40 link_clk = 1'b1;
            #40 link_clk = 1'b0;
        end
        frame_active = 1'b0;
        #200 sel_q = 1'b1;
        busy = 1'b0;
    end
endmodule
`default_nettype wire

// file: testbench.sv
// Register-level test of the serial control block.
`timescale 1ns/1ps
`default_nettype none
module testbench;
    logic clk = 1'b0;
    logic rst_n = 1'b0;
    logic sfr_wr = 1'b0, sfr_rd = 1'b0, data_reg_wr = 1'b0, tx_load = 1'b0, rx_full = 1'b0;
    logic master_enable = 1'b0, go = 1'b0, hold_sel = 1'b0;
    logic [7:0] sfr_addr = 8'h00, sfr_wdata = 8'h00, sfr_rdata;
    logic [3:0] nbits = 4'h8;
    logic link_clk, frame_active, sel_pin, busy, pin_out, pin_oe, routed, port_enable, irq_req, ss_in;
    logic [2:0] pins [4] = '{3'b100, 3'b101, 3'b011, 3'b111};
    int fail_count = 0, compares = 0, cycles = 0;
    // Wire level: the device drives it while its pin output enable is high, else the partner.
    assign ss_in = pin_oe ? pin_out : sel_pin;
    always #20 clk = ~clk;
    scs_spi_control u_scs_spi_control (.clk, .rst_n, .link_clk, .sfr_wr, .sfr_rd, .sfr_addr, .sfr_wdata,
        .sfr_rdata, .data_reg_wr, .tx_load, .rx_buffer_full(rx_full), .master_enable,
        .link_frame_active(frame_active), .slave_select_pin_in(ss_in), .slave_select_pin_out(pin_out),
        .slave_select_pin_oe(pin_oe), .slave_select_routed(routed), .port_enable, .irq_req);
    scs_link_partner u_scs_link_partner (.go, .nbits, .hold_sel, .link_clk, .frame_active, .sel_pin, .busy);
    task chk(input logic [7:0] seen, input logic [7:0] exp);
        compares++;
        if (seen !== exp)
        begin
            $display("Error at %0t seen %h expected %h", $time, seen, exp);
            fail_count++;
        end
    endtask
    task wr(input logic [7:0] a, input logic [7:0] d);
        @(posedge clk);
        #1 {sfr_wr, sfr_addr, sfr_wdata} = {1'b1, a, d};
        @(posedge clk);
        #1 sfr_wr = 1'b0;
    endtask
    task rd(input logic [7:0] a, input logic [7:0] exp);
        @(posedge clk);
        #1 {sfr_rd, sfr_addr} = {1'b1, a};
        @(posedge clk);
        #1 sfr_rd = 1'b0;
        chk(sfr_rdata, exp);
    endtask
    // One-cycle pulse on the data write or on the buffer move.
    task strobe(input logic w);
        @(posedge clk);
        #1 {data_reg_wr, tx_load} = {w, !w};
        @(posedge clk);
        #1 {data_reg_wr, tx_load} = 2'b00;
    endtask
    // Run a frame and allow the event to cross into the system clock.
    task frame(input logic [3:0] n);
        @(posedge clk);
        #1 {nbits, go} = {n, 1'b1};
        @(posedge clk);
        #1 go = 1'b0;
        for (int i = 0; i < 100 && busy; i++) @(posedge clk);
        repeat (6) @(posedge clk);
    endtask
    task finish_test;
        $display("Mismatches %0d in %0d comparisons", fail_count, compares);
        if (fail_count == 0 && compares > 0)
            $display("RESULT: PASS");
        else
            $display("RESULT: FAIL");
        $finish;
    endtask
    // Cut a hang short.
    always @(posedge clk)
    begin
        cycles++;
        if (cycles == 5000)
        begin
            fail_count++;
            finish_test();
        end
    end
    initial
    begin
        repeat (16) @(posedge clk);
        #1 rst_n = 1'b1;
        rd(8'hf8, 8'h06);
        chk({3'h0, pin_out, pin_oe, routed, port_enable, irq_req}, 8'h14);
        rd(8'h10, 8'h00);
        wr(8'hf8, 8'h05);
        rd(8'hf8, 8'h07);
        chk({7'h0, port_enable}, 8'h01);
        frame(4'h8);
        rd(8'hf8, 8'h87);
        chk({7'h0, irq_req}, 8'h01);
        rd(8'hf8, 8'h87);
        wr(8'hf8, 8'h05);
        // Two cut frames in a row must not add up to a full one.
        frame(4'h5);
        frame(4'h5);
        rd(8'hf8, 8'h07);
        chk({7'h0, irq_req}, 8'h00);
        strobe(1'b1);
        rd(8'hf8, 8'h05);
        strobe(1'b1);
        rd(8'hf8, 8'h45);
        strobe(1'b0);
        rd(8'hf8, 8'h47);
        wr(8'hf8, 8'h05);
        // Software writes only once the buffer reads empty.
        strobe(1'b1);
        rd(8'hf8, 8'h05);
        strobe(1'b0);
        master_enable = 1'b1;
        hold_sel = 1'b1;
        repeat (4) @(posedge clk);
        rd(8'hf8, 8'h27);
        chk({7'h0, irq_req}, 8'h01);
        {master_enable, hold_sel} = 2'b00;
        repeat (4) @(posedge clk);
        wr(8'hf8, 8'h05);
        rx_full = 1'b1;
        frame(4'h8);
        rd(8'hf8, 8'h97);
        rx_full = 1'b0;
        wr(8'hf8, 8'h05);
        for (int m = 0; m < 4; m++)
        begin
            wr(8'hf8, {4'h0, 2'(m), 2'h1});
            repeat (2) @(posedge clk);
            #1;
            chk({5'h0, pin_out, pin_oe, routed}, {5'h0, pins[m]});
        end
        wr(8'hf8, 8'h04);
        chk({7'h0, port_enable}, 8'h00);
        frame(4'h8);
        rd(8'hf8, 8'h06);
        finish_test();
    end
endmodule
`default_nettype wire
